// file: hw/input_voltage_limit_fault_response.sv
// input-voltage limit registers, fault response engine and management-link slave
`timescale 1ns/1ps
module input_voltage_limit_fault_response
   import vin_limit_pkg::*;
#(
   parameter int unsigned delay_unit_cycles = DELAY_UNIT_CYCLES
) (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        resetn,
   // management link, open drain
   input  wire logic        scl,
   input  wire logic        sda_in,
   output wire logic        sda_out,
   output wire logic        sda_oe_n,
   // remote control pin and measured input voltage
   input  wire logic        ctrl_pin,
   input  wire logic [15:0] vin_meas,
   // converter controls
   output logic             power_enable,
   output logic             ratio_switch_active,
   output logic             fault_latched
);
   typedef enum {b_idle, b_rx, b_ack, b_tx, b_tack} bus_state_t;
   typedef enum {f_run, f_ride, f_wait, f_latched} fault_state_t;
   bus_state_t   bst_q;
   fault_state_t fst_q, fst_d;
   logic [1:0]   scl_s, sda_s, ctrl_s;
   logic         scl_p, sda_p;
   logic [3:0]   bitcnt_q;
   logic [7:0]   sh_q, txb_q, cmd_q;
   logic [1:0]   idx_q;
   logic         rd_q, nack_q, oe_n_q;
   logic [15:0]  ovw_q, uvw_q, uvf_q, rd_word;
   logic [7:0]   lo_q, act_byte_q, op_q, opt_q, status_q;
   logic [31:0]  tmr_q, tmr_d, dly_cycles;
   logic [2:0]   att_q, att_d;
   logic         scl_rise, scl_fall, start_c, stop_c, byte_done;
   logic         wr_lo, wr_hi, clr_cmd, clr_bit, clr_evt, cmd_on, uv, uvw, ovw;
   logic [1:0]   act;
   logic [2:0]   rtry, dly;

   // two-stage synchronisers; the second stage and, for the link pins, a delayed copy of it feed logic
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         scl_s <= 2'h3;
         sda_s <= 2'h3;
         ctrl_s <= 2'h0;
         scl_p <= 1'b1;
         sda_p <= 1'b1;
      end else begin
         scl_s <= {scl_s[0], scl};
         sda_s <= {sda_s[0], sda_in};
         ctrl_s <= {ctrl_s[0], ctrl_pin};
         scl_p <= scl_s[1];
         sda_p <= sda_s[1];
      end
   end

   // link events seen from the settled samples
   assign scl_rise = scl_s[1] & ~scl_p;
   assign scl_fall = ~scl_s[1] & scl_p;
   assign start_c = scl_s[1] & scl_p & sda_p & ~sda_s[1];
   assign stop_c = scl_s[1] & scl_p & ~sda_p & sda_s[1];
   assign byte_done = (bst_q == b_rx) && scl_fall && (bitcnt_q == 4'h8);
   assign wr_lo = byte_done && (idx_q == 2'h2);
   assign wr_hi = byte_done && (idx_q == 2'h3);
   assign clr_cmd = byte_done && (idx_q == 2'h1) && (sh_q == CMD_CLEAR_FAULTS);
   assign clr_bit = wr_lo && (cmd_q == CMD_STATUS_INPUT) && sh_q[ST_UV_FAULT_BIT];
   assign sda_out = 1'b0;
   assign sda_oe_n = oe_n_q;

   // read data for the addressed command, low byte first
   always_comb begin
      case (cmd_q)
         CMD_OV_WARN: rd_word = ovw_q;
         CMD_UV_WARN: rd_word = uvw_q;
         CMD_UV_FAULT: rd_word = uvf_q;
         CMD_UV_ACTION: rd_word = {8'h00, act_byte_q};
         CMD_OPERATION: rd_word = {8'h00, op_q};
         CMD_SPECIAL_OPTIONS: rd_word = {8'h00, opt_q};
         CMD_STATUS_INPUT: rd_word = {8'h00, status_q};
         default: rd_word = 16'h0000;
      endcase
   end

   // link slave: address, command, data bytes, ack and read shifting
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         bst_q <= b_idle;
         bitcnt_q <= 4'h0;
         sh_q <= 8'h00;
         txb_q <= 8'h00;
         cmd_q <= 8'h00;
         idx_q <= 2'h0;
         rd_q <= 1'b0;
         nack_q <= 1'b0;
         oe_n_q <= 1'b1;
      end else if (stop_c) begin
         bst_q <= b_idle;
         oe_n_q <= 1'b1;
      end else if (start_c) begin
         bst_q <= b_rx;
         bitcnt_q <= 4'h0;
         idx_q <= 2'h0;
         oe_n_q <= 1'b1;
      end else
         case (bst_q)
            b_rx:
               if (scl_rise) begin
                  sh_q <= {sh_q[6:0], sda_s[1]};
                  bitcnt_q <= bitcnt_q + 4'h1;
               end else if (byte_done) begin
                  bitcnt_q <= 4'h0;
                  if (idx_q == 2'h0 && sh_q[7:1] != DEV_ADDR) begin
                     bst_q <= b_idle; // not ours: stay released
                  end else begin
                     bst_q <= b_ack;
                     oe_n_q <= 1'b0;
                     if (idx_q != 2'h3)
                        idx_q <= idx_q + 2'h1;
                     if (idx_q == 2'h0)
                        rd_q <= sh_q[0];
                     if (idx_q == 2'h1)
                        cmd_q <= sh_q;
                  end
               end
            b_ack:
               if (scl_fall) begin
                  if (rd_q) begin
                     bst_q <= b_tx;
                     oe_n_q <= rd_word[7];
                     txb_q <= {rd_word[6:0], 1'b0};
                  end else begin
                     bst_q <= b_rx;
                     oe_n_q <= 1'b1;
                  end
               end
            b_tx:
               if (scl_rise) begin
                  bitcnt_q <= bitcnt_q + 4'h1;
               end else if (scl_fall) begin
                  if (bitcnt_q == 4'h8) begin
                     bst_q <= b_tack;
                     bitcnt_q <= 4'h0;
                     oe_n_q <= 1'b1;
                  end else begin
                     oe_n_q <= txb_q[7];
                     txb_q <= {txb_q[6:0], 1'b0};
                  end
               end
            b_tack:
               if (scl_rise) begin
                  nack_q <= sda_s[1];
               end else if (scl_fall) begin
                  if (nack_q) begin
                     bst_q <= b_idle;
                  end else begin
                     bst_q <= b_tx; // further bytes repeat the high byte
                     oe_n_q <= rd_word[15];
                     txb_q <= {rd_word[14:8], 1'b0};
                  end
               end
            default: bst_q <= b_idle;
         endcase
   end

   // host-writable registers; word registers commit on the high byte
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         ovw_q <= OV_WARN_RST;
         uvw_q <= UV_WARN_RST;
         uvf_q <= UV_FAULT_RST;
         act_byte_q <= UV_ACTION_RST;
         op_q <= OPERATION_RST;
         opt_q <= OPTIONS_RST;
         lo_q <= 8'h00;
      end else if (wr_lo) begin
         lo_q <= sh_q;
         case (cmd_q)
            CMD_UV_ACTION: act_byte_q <= sh_q;
            CMD_OPERATION: op_q <= sh_q;
            CMD_SPECIAL_OPTIONS: opt_q <= sh_q;
            default: ;
         endcase
      end else if (wr_hi) begin
         case (cmd_q)
            CMD_OV_WARN: ovw_q <= {sh_q, lo_q};
            CMD_UV_WARN: uvw_q <= {sh_q, lo_q};
            CMD_UV_FAULT: uvf_q <= {sh_q, lo_q};
            default: ;
         endcase
      end
   end

   // limit comparisons against the measured input
   assign uv = vin_meas < uvf_q;
   assign uvw = vin_meas < uvw_q;
   assign ovw = vin_meas > ovw_q;
   assign act = act_byte_q[ACT_HI:ACT_LO];
   assign rtry = act_byte_q[RTRY_HI:RTRY_LO];
   assign dly = act_byte_q[DLY_HI:DLY_LO];
   assign dly_cycles = (delay_unit_cycles << dly) - 32'h1;
   assign cmd_on = op_q[OP_ON_BIT] & ctrl_s[1];
   assign clr_evt = clr_cmd | clr_bit;

   // sticky input status; a new event wins over a write-one clear
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         status_q <= 8'h00;
      end else begin
         if (wr_lo && cmd_q == CMD_STATUS_INPUT)
            status_q <= status_q & ~sh_q;
         if (clr_cmd)
            status_q <= 8'h00;
         if (ovw) status_q[ST_OV_WARN_BIT] <= 1'b1;
         if (uvw) status_q[ST_UV_WARN_BIT] <= 1'b1;
         if (uv) status_q[ST_UV_FAULT_BIT] <= 1'b1;
      end
   end

   // fault response; commanded off parks in run so turning on clears a latch
   always_comb begin
      fst_d = fst_q;
      att_d = att_q;
      tmr_d = (tmr_q != 32'h0) ? tmr_q - 32'h1 : tmr_q;
      if (!cmd_on) begin
         fst_d = f_run;
         att_d = 3'h0;
      end else
         case (fst_q)
            f_run:
               if (uv)
                  case (act)
                     ACT_RIDE: begin
                        fst_d = f_ride;
                        tmr_d = dly_cycles;
                     end
                     ACT_RETRY: begin
                        fst_d = (rtry == RTRY_NONE) ? f_latched : f_wait;
                        tmr_d = dly_cycles;
                     end
                     ACT_LATCH: fst_d = f_latched;
                     default: ;
                  endcase
            f_ride:
               if (!uv) begin
                  fst_d = f_run;
               end else if (tmr_q == 32'h0) begin
                  fst_d = (rtry == RTRY_NONE) ? f_latched : f_wait;
                  tmr_d = dly_cycles;
               end
            f_wait:
               if (tmr_q == 32'h0) begin
                  tmr_d = dly_cycles;
                  if (!uv) begin
                     fst_d = f_run;
                     att_d = 3'h0;
                  end else if (rtry != RTRY_FOREVER &&
                               {1'b0, att_q} + 4'h1 >= {1'b0, rtry}) begin
                     fst_d = f_latched;
                  end else begin
                     att_d = att_q + 3'h1;
                  end
               end
            f_latched:
               if (clr_evt) begin
                  fst_d = f_run;
                  att_d = 3'h0;
               end
            default: fst_d = f_run;
         endcase
   end

   // fault state and converter outputs
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         fst_q <= f_run;
         att_q <= 3'h0;
         tmr_q <= 32'h0;
         power_enable <= 1'b0;
         fault_latched <= 1'b0;
         ratio_switch_active <= 1'b0;
      end else begin
         fst_q <= fst_d;
         att_q <= att_d;
         tmr_q <= tmr_d;
         power_enable <= cmd_on && (fst_d == f_run || fst_d == f_ride);
         fault_latched <= (fst_d == f_latched);
         ratio_switch_active <= opt_q[OPT_RATIO_BIT] & uvw;
      end
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   a_ignore_keeps_on: assert property ((fst_q == f_run && act == ACT_IGNORE && cmd_on)
      |=> power_enable) else $error("ignore action dropped output");
   a_disable_now: assert property ((fst_q == f_run && uv && act == ACT_RETRY && cmd_on)
      |=> !power_enable && fst_q != f_run) else $error("disable action late");
   a_latch_holds: assert property ((fst_q == f_latched && cmd_on && !clr_evt)
      |=> fst_q == f_latched && !power_enable) else $error("latch released");
   a_zero_retry: assert property ((fst_q == f_run && uv && act == ACT_RETRY && cmd_on
      && rtry == RTRY_NONE) |=> fault_latched) else $error("zero retry restarted");
   a_ride_running: assert property (fst_q == f_ride |-> power_enable)
      else $error("ride-through dropped output");
   a_clear_latch: assert property ((fst_q == f_latched && clr_evt)
      |=> fst_q != f_latched) else $error("clear ignored");
   a_off_on_clear: assert property ((fst_q == f_latched && !cmd_on)
      |=> fst_q == f_run) else $error("off did not clear");
   a_retry_bound: assert property ((fst_q == f_wait && rtry != RTRY_FOREVER && cmd_on)
      |-> att_q < rtry) else $error("too many restarts");
   a_ratio_switch: assert property (ratio_switch_active ==
      $past(opt_q[OPT_RATIO_BIT] & uvw)) else $error("ratio switch wrong");
   a_ack_drive: assert property ($rose(bst_q == b_ack) |-> !sda_oe_n)
      else $error("ack not driven");
endmodule

// file: hw/vin_limit_pkg.sv
// constants for the input-voltage limit and fault-response block
package vin_limit_pkg;
   // command codes on the management link
   localparam logic [7:0] CMD_OPERATION       = 8'h01;
   localparam logic [7:0] CMD_CLEAR_FAULTS    = 8'h03;
   localparam logic [7:0] CMD_OV_WARN         = 8'h57;
   localparam logic [7:0] CMD_UV_WARN         = 8'h58;
   localparam logic [7:0] CMD_UV_FAULT        = 8'h59;
   localparam logic [7:0] CMD_UV_ACTION       = 8'h5A;
   localparam logic [7:0] CMD_STATUS_INPUT    = 8'h7C;
   localparam logic [7:0] CMD_SPECIAL_OPTIONS = 8'hE0;
   localparam logic [6:0] DEV_ADDR            = 7'h40;
   // field positions
   localparam int ACT_HI = 7;
   localparam int ACT_LO = 6;
   localparam int RTRY_HI = 5;
   localparam int RTRY_LO = 3;
   localparam int DLY_HI = 2;
   localparam int DLY_LO = 0;
   localparam int OP_ON_BIT = 7;
   localparam int OPT_RATIO_BIT = 0;
   localparam int ST_OV_WARN_BIT = 6;
   localparam int ST_UV_WARN_BIT = 5;
   localparam int ST_UV_FAULT_BIT = 4;
   // action and retry codes
   localparam logic [1:0] ACT_IGNORE = 2'h0;
   localparam logic [1:0] ACT_RIDE = 2'h1;
   localparam logic [1:0] ACT_RETRY = 2'h2;
   localparam logic [1:0] ACT_LATCH = 2'h3;
   localparam logic [2:0] RTRY_NONE = 3'h0;
   localparam logic [2:0] RTRY_FOREVER = 3'h7;
   // reset values
   localparam logic [15:0] OV_WARN_RST = 16'hFFFF;
   localparam logic [15:0] UV_WARN_RST = 16'h0000;
   localparam logic [15:0] UV_FAULT_RST = 16'h0000;
   localparam logic [7:0] UV_ACTION_RST = 8'hC0;
   localparam logic [7:0] OPERATION_RST = 8'h80;
   localparam logic [7:0] OPTIONS_RST = 8'h00;
   // timing
   localparam int CLK_MHZ = 10;
   localparam int DELAY_UNIT_US = 1000;
   localparam int DELAY_UNIT_CYCLES = DELAY_UNIT_US * CLK_MHZ;
endpackage

// file: tb/test_input_voltage_limit_fault_response.sv
// self-checking bench for the input-voltage limit and fault-response block
`timescale 1ns/1ps
module test_input_voltage_limit_fault_response
   import vin_limit_pkg::*;
;
   localparam int UNIT = 4;
   logic        mclk, resetn, ctrl_pin, ok;
   logic [15:0] vin_meas, w, r;
   wire logic   scl, sda_pull, sda_out, sda_oe_n, power_enable, ratio_switch_active, fault_latched;
   int          n_mismatch, compares, t, e;
   logic [2:0]  dl;
   logic [7:0]  cmds [3] = '{CMD_OV_WARN, CMD_UV_WARN, CMD_UV_FAULT};
   // open-drain data wire with pull-up
   wire logic   sda = !(sda_pull || (!sda_oe_n && !sda_out));
   // unit under test and host
   input_voltage_limit_fault_response #(.delay_unit_cycles(UNIT)) u_input_voltage_limit_fault_response (
      .mclk(mclk), .resetn(resetn), .scl(scl), .sda_in(sda), .sda_out(sda_out),
      .sda_oe_n(sda_oe_n), .ctrl_pin(ctrl_pin), .vin_meas(vin_meas), .power_enable(power_enable),
      .ratio_switch_active(ratio_switch_active), .fault_latched(fault_latched));
   vin_link_host u_vin_link_host (.mclk(mclk), .scl(scl), .sda_pull(sda_pull), .sda(sda));
   // 10 MHz clock
   always #50 mclk = !mclk;
   // comparisons
   task automatic check_word(input logic [15:0] g, input logic [15:0] x);
      compares++;
      if (g !== x) begin
         n_mismatch++;
         $display("Error at %0t: word %h, expected %h", $time, g, x);
      end
   endtask
   task automatic check_bit(input logic g, input logic x);
      compares++;
      if (g !== x) begin
         n_mismatch++;
         $display("Error at %0t: bit %b, expected %b", $time, g, x);
      end
   endtask
   // verdict
   task automatic stop_test();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // link wrappers that also check every acknowledge
   task automatic wr(input logic [7:0] c, input logic [15:0] d, input int n);
      u_vin_link_host.wr(c, d, n, ok);
      check_bit(ok, 1'b1);
   endtask
   task automatic rd(input logic [7:0] c, input int n);
      u_vin_link_host.rd(c, n, w, ok);
      check_bit(ok, 1'b1);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   // delay field in mclk cycles: unit times a power of two
   function automatic int span(input logic [2:0] d);
      return UNIT << d;
   endfunction
   // random input voltage below or above the 0x1000 fault limit
   task automatic setvin(input logic low);
      vin_meas = low ? 16'h0800 + 16'($urandom % 32'h700) : 16'h2000 + 16'($urandom % 32'hF00);
   endtask
   // back to running after a latched test
   task automatic recover();
      setvin(1'b0);
      wr(CMD_CLEAR_FAULTS, 16'h0000, 0);
      cyc(4);
      check_bit(power_enable, 1'b1);
   endtask
   // watchdog, far beyond the expected 2 ms
   initial begin
      #8000000;
      n_mismatch++;
      stop_test();
   end
   // main sequence
   initial begin
      mclk = 1'b0;
      resetn = 1'b0;
      ctrl_pin = 1'b1;
      vin_meas = 16'h2000;
      n_mismatch = 0;
      compares = 0;
      t = $urandom(32'h87028629);
      cyc(5);
      resetn = 1'b1;
      cyc(5);
      rd(CMD_OV_WARN, 2);
      check_word(w, OV_WARN_RST);
      rd(CMD_UV_WARN, 2);
      check_word(w, UV_WARN_RST);
      rd(CMD_UV_FAULT, 2);
      check_word(w, UV_FAULT_RST);
      rd(CMD_UV_ACTION, 1);
      check_word(w, {8'h00, UV_ACTION_RST});
      rd(8'h70, 2);
      check_word(w, 16'h0000);
      $display("test reset values done");
      // random round trips, then a lone low byte that must not commit
      for (int i = 0; i < 3; i++) begin
         r = 16'($urandom);
         wr(cmds[i], r, 2);
         wr(cmds[i], ~r, 1);
         rd(cmds[i], 2);
         check_word(w, r);
      end
      r = {8'h00, 8'($urandom)};
      wr(CMD_UV_ACTION, r, 1);
      rd(CMD_UV_ACTION, 1);
      check_word(w, r);
      $display("test register access done");
      // ratio switching follows the warning limit only when enabled
      wr(CMD_UV_FAULT, 16'h1000, 2);
      // drop any latch left behind by the random fault limit
      wr(CMD_CLEAR_FAULTS, 16'h0000, 0);
      wr(CMD_UV_WARN, 16'h3000, 2);
      wr(CMD_SPECIAL_OPTIONS, 16'h0001, 1);
      vin_meas = 16'h2FFF;
      cyc(4);
      check_bit(ratio_switch_active, 1'b1);
      vin_meas = 16'h3000;
      cyc(4);
      check_bit(ratio_switch_active, 1'b0);
      wr(CMD_SPECIAL_OPTIONS, 16'h0000, 1);
      vin_meas = 16'h2800;
      cyc(4);
      check_bit(ratio_switch_active, 1'b0);
      $display("test ratio switching done");
      // ignore: output stays on through the fault
      wr(CMD_UV_ACTION, {8'h00, ACT_IGNORE, 6'h00}, 1);
      setvin(1'b1);
      cyc(40);
      check_bit(power_enable, 1'b1);
      check_bit(fault_latched, 1'b0);
      // latch off, then the status-bit clear, pin toggle and operation toggle in turn
      wr(CMD_UV_ACTION, {8'h00, ACT_LATCH, 6'h00}, 1);
      for (int m = 0; m < 3; m++) begin
         setvin(1'b1);
         cyc(4);
         check_bit(power_enable, 1'b0);
         setvin(1'b0);
         cyc(20);
         check_bit(fault_latched, 1'b1);
         if (m == 0)
            wr(CMD_STATUS_INPUT, 16'h0010, 1);
         if (m == 1) begin
            ctrl_pin = 1'b0;
            cyc(6);
            ctrl_pin = 1'b1;
         end
         if (m == 2) begin
            wr(CMD_OPERATION, 16'h0000, 1);
            wr(CMD_OPERATION, {8'h00, OPERATION_RST}, 1);
         end
         cyc(6);
         check_bit(power_enable, 1'b1);
      end
      $display("test ignore and latch done");
      // disable and retry: latch after rtry spaced attempts, longest delay on 6
      for (int n = 0; n < 7; n++) begin
         dl = (n == 6) ? 3'h7 : 3'($urandom % 4);
         wr(CMD_UV_ACTION, {8'h00, ACT_RETRY, 3'(n), dl}, 1);
         setvin(1'b1);
         cyc(3);
         check_bit(power_enable, 1'b0);
         t = 0;
         e = n * span(dl);
         while (fault_latched !== 1'b1 && t < e + 100) begin
            cyc(1);
            t++;
         end
         check_bit(t + 4 >= e && t <= e + 2 * n + 6, 1'b1);
         recover();
      end
      // a restart that succeeds once the input is back
      wr(CMD_UV_ACTION, {8'h00, ACT_RETRY, 3'h1, 3'h2}, 1);
      setvin(1'b1);
      cyc(3);
      setvin(1'b0);
      cyc(span(3'h2) - 8);
      check_bit(power_enable, 1'b0);
      cyc(12);
      check_bit(power_enable, 1'b1);
      check_bit(fault_latched, 1'b0);
      $display("test retries done");
      // ride through: stays on for the delay, then no retry means latch
      wr(CMD_UV_ACTION, {8'h00, ACT_RIDE, RTRY_NONE, 3'h3}, 1);
      setvin(1'b1);
      cyc(span(3'h3) - 4);
      check_bit(power_enable, 1'b1);
      cyc(10);
      check_bit(fault_latched, 1'b1);
      recover();
      // ride through with the fault gone before the delay ends
      setvin(1'b1);
      cyc(10);
      setvin(1'b0);
      cyc(40);
      check_bit(power_enable, 1'b1);
      // unlimited retries never latch
      wr(CMD_UV_ACTION, {8'h00, ACT_RETRY, RTRY_FOREVER, 3'h0}, 1);
      setvin(1'b1);
      cyc(300);
      check_bit(fault_latched, 1'b0);
      setvin(1'b0);
      cyc(12);
      check_bit(power_enable, 1'b1);
      $display("test ride and forever done");
      // a mid-run reset clears a latch and restores the limits
      wr(CMD_UV_ACTION, {8'h00, ACT_LATCH, 6'h00}, 1);
      setvin(1'b1);
      cyc(4);
      check_bit(fault_latched, 1'b1);
      resetn = 1'b0;
      cyc(5);
      check_bit(fault_latched, 1'b0);
      resetn = 1'b1;
      cyc(5);
      check_bit(power_enable, 1'b1);
      rd(CMD_UV_FAULT, 2);
      check_word(w, UV_FAULT_RST);
      $display("test reset clear done");
      stop_test();
   end
endmodule

// file: tb/vin_link_host.sv
// management-link host model driving the clock and the open-drain data line
`timescale 1ns/1ps
module vin_link_host
   import vin_limit_pkg::*;
(
   // clock used to place link edges
   input  wire logic mclk,
   // link pins; sda_pull high pulls data low
   output logic      scl,
   output logic      sda_pull,
   input  wire logic sda
);
   // idle: clock driven high, data left to the pull-up, clock stands still
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end
   // wait n cycles, landing just after a rising edge
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   // one bit: 6 cycles low, 2 high; data moves a cycle after the fall,
   // so the synchroniser never sees data and clock change together
   task automatic bit_io(input logic b, output logic r);
      tick(1);
      sda_pull = !b;
      tick(5);
      scl = 1'b1;
      tick(2);
      r = sda;
      scl = 1'b0;
   endtask
   // start or repeated start: data falls while clock is high
   task automatic start();
      tick(1);
      sda_pull = 1'b0;
      tick(5);
      scl = 1'b1;
      tick(3);
      sda_pull = 1'b1;
      tick(3);
      scl = 1'b0;
   endtask
   // stop: data rises while clock is high
   task automatic stop();
      tick(1);
      sda_pull = 1'b1;
      tick(5);
      scl = 1'b1;
      tick(3);
      sda_pull = 1'b0;
      tick(8);
   endtask
   // one byte msb first plus the acknowledge bit
   task automatic xfer(input logic [7:0] tx, input logic ai, output logic [7:0] rx,
                       output logic ao);
      for (int i = 7; i >= 0; i--)
         bit_io(tx[i], rx[i]);
      bit_io(ai, ao);
   endtask
   // write with n data bytes, low byte first; n of 0 is the clear-faults send byte
   task automatic wr(input logic [7:0] c, input logic [15:0] d, input int n, output logic ok);
      logic [7:0] r;
      logic       a;
      logic [7:0] b [4];
      b = '{{DEV_ADDR, 1'b0}, c, d[7:0], d[15:8]};
      ok = 1'b1;
      start();
      for (int i = 0; i < n + 2; i++) begin
         xfer(b[i], 1'b1, r, a);
         ok &= !a;
      end
      stop();
   endtask
   // read of n bytes after a repeated start; last byte refused to end the read
   task automatic rd(input logic [7:0] c, input int n, output logic [15:0] d, output logic ok);
      logic [7:0] r;
      logic       a, b, e;
      start();
      xfer({DEV_ADDR, 1'b0}, 1'b1, r, a);
      xfer(c, 1'b1, r, b);
      start();
      xfer({DEV_ADDR, 1'b1}, 1'b1, r, e);
      ok = !(a || b || e);
      d[15:8] = 8'h00;
      xfer(8'hFF, n == 1, d[7:0], a);
      if (n > 1)
         xfer(8'hFF, 1'b1, d[15:8], a);
      stop();
   endtask
endmodule
